// [src/cos_selector.sv]
// Purpose: contact output selector with three configurable channels
// Assumes: register port master per plain strobe protocol, one clock domain
// Notes:   contact inputs are pins and pass a two-stage synchroniser
`timescale 1ns/1ps
module cos_selector
	import cos_pkg::*;
(
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst,
	// register port
	input  wire logic [3:0]           reg_addr,
	input  wire logic [31:0]          reg_wdata,
	input  wire logic                 reg_wr,
	input  wire logic                 reg_rd,
	output logic      [31:0]          reg_rdata,
	// product conditions, same clock domain
	input  wire cos_pkg::cos_cond_s   cond,
	// customer pins: contact inputs and remote input (alternate type)
	input  wire logic                 contact_in1,
	input  wire logic                 contact_in2,
	input  wire logic                 remote_in,
	// contact outputs, 1 = closed
	output logic [cos_pkg::COS_CHANNELS-1:0] contact_out
);
	import cos_pkg::*;

	cos_cfg_s        cfg_r [COS_CHANNELS];
	logic [2:0]      sync1_r;
	logic [2:0]      sync2_r;
	logic            contact_input_remote_state;
	logic [31:0]     rdata_nxt;

	// decode a source to its condition level
	function automatic logic src_level(input cos_src_e s, input cos_cond_s c,
		input logic remote_status_source, input logic i1, input logic i2);
		case (s)
			COS_SRC_NONE:   src_level = 1'b0;
			COS_SRC_RUN:    src_level = c.operating;
			COS_SRC_REMOTE: src_level = remote_status_source;
			COS_SRC_READY:  src_level = c.ready;
			COS_SRC_ASTOP:  src_level = c.alarm_stop;
			COS_SRC_ACONT:  src_level = c.alarm_cont;
			COS_SRC_ALARM:  src_level = c.alarm_stop | c.alarm_cont;
			COS_SRC_ASEL:   src_level = c.alarm_sel;
			COS_SRC_ONTMR:  src_level = c.start_timer;
			COS_SRC_OFFTMR: src_level = c.stop_timer;
			COS_SRC_PRST:   src_level = c.pwr_recover;
			COS_SRC_FREEZE: src_level = c.anti_freeze;
			COS_SRC_WARM:   src_level = c.warm_up;
			COS_SRC_INPUT_ONE_PASS_THROUGH:   src_level = i1;
			COS_SRC_INPUT_TWO_PASS_THROUGH:   src_level = i2;
			default:        src_level = 1'b0;
		endcase
	endfunction : src_level

	// pin synchroniser; first stage feeds only the second
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sync1_r <= 3'h0;
			sync2_r <= 3'h0;
		end else begin
			sync1_r <= {remote_in, contact_in2, contact_in1};
			sync2_r <= sync1_r;
		end
	end

	// remote state follows the held alternate input; momentary toggling is not modelled
	assign contact_input_remote_state = sync2_r[2];

	// channel configuration, writable by software
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cfg_r[0] <= COS_CH1_RST;
			cfg_r[1] <= COS_CH2_RST;
			cfg_r[2] <= COS_CH3_RST;
		end else if (reg_wr && reg_addr <= COS_REG_CH3) begin
			cfg_r[reg_addr[1:0]] <= '{pol: reg_wdata[COS_F_POL_BIT],
				src: cos_src_e'(reg_wdata[COS_F_SEL_LSB +: COS_SEL_W])};
		end
	end

	// read mux; unmapped addresses read zero
	always_comb begin
		rdata_nxt = 32'h0;
		case (reg_addr)
			COS_REG_CH1, COS_REG_CH2, COS_REG_CH3: begin
				rdata_nxt[COS_F_SEL_LSB +: COS_SEL_W] = cfg_r[reg_addr[1:0]].src;
				rdata_nxt[COS_F_POL_BIT]              = cfg_r[reg_addr[1:0]].pol;
			end
			COS_REG_STATUS: begin
				rdata_nxt[COS_CHANNELS-1:0] = contact_out;
			end
			default: rdata_nxt = 32'h0;
		endcase
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			reg_rdata <= rdata_nxt;
		end else begin
			reg_rdata <= 32'h0;
		end
	end

	// outputs registered so relays never see decode glitches
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			contact_out <= '0; // open, as with power removed
		end else begin
			for (int i = 0; i < COS_CHANNELS; i++) begin
				contact_out[i] <= src_level(cfg_r[i].src, cond, contact_input_remote_state,
					sync2_r[0], sync2_r[1]) ^ (cfg_r[i].pol == COS_POL_NC);
			end
		end
	end

	// ---- checks ----
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	none_no_open_a: assert property (
		cfg_r[0] == cos_cfg_s'{pol: COS_POL_NO, src: COS_SRC_NONE} |=> !contact_out[0])
		else $error("none source with N.O did not open");
	none_nc_closed_a: assert property (
		cfg_r[1] == cos_cfg_s'{pol: COS_POL_NC, src: COS_SRC_NONE} |=> contact_out[1])
		else $error("none source with N.C did not close");
	run_follow_a: assert property (
		cfg_r[0].src == COS_SRC_RUN |=> contact_out[0] ==
			($past(cond.operating) ^ $past(cfg_r[0].pol)))
		else $error("run source output wrong");
	alarm_any_a: assert property (
		cfg_r[2].src == COS_SRC_ALARM && (cond.alarm_stop || cond.alarm_cont)
		|=> contact_out[2] == !$past(cfg_r[2].pol))
		else $error("any alarm output wrong");
	sel_alarm_nc_a: assert property (
		cfg_r[2] == cos_cfg_s'{pol: COS_POL_NC, src: COS_SRC_ASEL} && cond.alarm_sel
		|=> !contact_out[2])
		else $error("selected alarm with N.C did not open");

	// one step of the output register: the channel shows last cycle's level,
	// inverted when the polarity bit asks for normally closed
	sequence src_sel_s(int ch, cos_src_e code);
		cfg_r[ch].src == code;
	endsequence
	property src_follow_p(int ch, cos_src_e code, logic lvl);
		src_sel_s(ch, code) |=> contact_out[ch] == ($past(lvl) ^ $past(cfg_r[ch].pol));
	endproperty

	// every source code is watched on at least one channel
	none_src_a: assert property (src_follow_p(2, COS_SRC_NONE, 1'b0))
		else $error("none source output wrong");
	run_src_a: assert property (src_follow_p(1, COS_SRC_RUN, cond.operating))
		else $error("run source output wrong on channel two");
	remote_src_a: assert property (
		src_follow_p(0, COS_SRC_REMOTE, contact_input_remote_state))
		else $error("remote source output wrong");
	ready_src_a: assert property (src_follow_p(2, COS_SRC_READY, cond.ready))
		else $error("ready source output wrong");
	astop_src_a: assert property (src_follow_p(0, COS_SRC_ASTOP, cond.alarm_stop))
		else $error("stop alarm source output wrong");
	acont_src_a: assert property (src_follow_p(1, COS_SRC_ACONT, cond.alarm_cont))
		else $error("continue alarm source output wrong");
	any_alarm_src_a: assert property (
		src_follow_p(0, COS_SRC_ALARM, cond.alarm_stop | cond.alarm_cont))
		else $error("any alarm source output wrong");
	asel_src_a: assert property (src_follow_p(1, COS_SRC_ASEL, cond.alarm_sel))
		else $error("selected alarm source output wrong");
	ontmr_src_a: assert property (src_follow_p(2, COS_SRC_ONTMR, cond.start_timer))
		else $error("start timer source output wrong");
	offtmr_src_a: assert property (src_follow_p(0, COS_SRC_OFFTMR, cond.stop_timer))
		else $error("stop timer source output wrong");
	prst_src_a: assert property (src_follow_p(1, COS_SRC_PRST, cond.pwr_recover))
		else $error("power recovery source output wrong");
	freeze_src_a: assert property (src_follow_p(2, COS_SRC_FREEZE, cond.anti_freeze))
		else $error("anti-freeze source output wrong");
	warm_src_a: assert property (src_follow_p(0, COS_SRC_WARM, cond.warm_up))
		else $error("warm-up source output wrong");
	input_one_pass_through_src_a: assert property (src_follow_p(1, COS_SRC_INPUT_ONE_PASS_THROUGH, sync2_r[0]))
		else $error("input one pass-through output wrong");
	input_two_pass_through_src_a: assert property (src_follow_p(2, COS_SRC_INPUT_TWO_PASS_THROUGH, sync2_r[1]))
		else $error("input two pass-through output wrong");
	spare_src_a: assert property (
		src_follow_p(0, cos_src_e'(4'hF), 1'b0))
		else $error("unused source code did not act as none");
	sequence in1_rise_s;
		cfg_r[0].src == COS_SRC_INPUT_ONE_PASS_THROUGH && cfg_r[0].pol == COS_POL_NO && contact_in1 [*4];
	endsequence
	input_one_pass_through_pass_a: assert property (
		in1_rise_s |-> contact_out[0])
		else $error("input one pass-through lagging");
	remote_state_a: assert property (
		remote_in [*3] |-> contact_input_remote_state)
		else $error("remote state not entered");
	cfg_write_a: assert property (
		reg_wr && reg_addr == COS_REG_CH2 |=> cfg_r[1].pol == $past(reg_wdata[COS_F_POL_BIT]))
		else $error("channel config write lost");
	rd_pulse_a: assert property (
		!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data outside its cycle");

endmodule : cos_selector

// [src/cos_pkg.sv]
// Purpose: constants and types for the contact output selector
// Assumes: one 125 MHz clock, asynchronous active-high reset
// Notes:   three channels, each a source select and a polarity bit
//
// Functional notes
// - three independent contact outputs, each closed or open per its selected condition.
// - defaults: ch1 run status N.O, ch2 remote status N.O, ch3 alarm N.C.
// - software may change each channel's source and polarity.
// - source none: open for N.O, closed for N.C.
// - run source: closed while operating for N.O, open for N.C.
// - remote source: closed in contact-input remote state for N.O, open for N.C.
// - ready source: closed at ready completion for N.O, open for N.C.
// - stop-alarm source: closed while stopping alarm active for N.O, open for N.C.
// - continue-alarm source: closed while continuing alarm active for N.O, open for N.C.
// - any-alarm source: closed while any alarm active for N.O, open for N.C.
// - selected-alarm source with N.O closes while a selected alarm is active.
// - start-timer source: closed while start timer set for N.O, open for N.C.
// - stop-timer source: closed while stop timer set for N.O, open for N.C.
// - power-fail recovery source: closed while enabled for N.O, open for N.C.
// - anti-freeze source: closed while enabled for N.O, open for N.C.
// - warm-up source: closed while enabled for N.O, open for N.C.
// - input one pass-through follows contact input 1, inverted for N.C.
// - input two pass-through follows contact input 2, inverted for N.C.
// - pass-through is only faithful for alternate-type inputs, not momentary.
// - remote state holds while an alternate remote input is held on.
package cos_pkg;

	localparam int COS_CHANNELS = 3;
	localparam int COS_SEL_W    = 4;

	// source codes; the value stored in the select field
	typedef enum logic [3:0] {
		COS_SRC_NONE    = 4'h0,
		COS_SRC_RUN     = 4'h1,
		COS_SRC_REMOTE  = 4'h2,
		COS_SRC_READY   = 4'h3,
		COS_SRC_ASTOP   = 4'h4,
		COS_SRC_ACONT   = 4'h5,
		COS_SRC_ALARM   = 4'h6,
		COS_SRC_ASEL    = 4'h7,
		COS_SRC_ONTMR   = 4'h8,
		COS_SRC_OFFTMR  = 4'h9,
		COS_SRC_PRST    = 4'hA,
		COS_SRC_FREEZE  = 4'hB,
		COS_SRC_WARM    = 4'hC,
		COS_SRC_INPUT_ONE_PASS_THROUGH    = 4'hD,
		COS_SRC_INPUT_TWO_PASS_THROUGH    = 4'hE
	} cos_src_e;

	// polarity: normally open passes, normally closed inverts
	localparam logic COS_POL_NO = 1'b0;
	localparam logic COS_POL_NC = 1'b1;

	// register map, word offsets (byte address = 4 * index)
	localparam logic [3:0] COS_REG_CH1    = 4'h0;
	localparam logic [3:0] COS_REG_CH2    = 4'h1;
	localparam logic [3:0] COS_REG_CH3    = 4'h2;
	localparam logic [3:0] COS_REG_STATUS = 4'h3;

	// channel config word layout
	localparam int COS_F_SEL_LSB = 0;
	localparam int COS_F_POL_BIT = 4;

	typedef struct packed {
		logic     pol;
		cos_src_e src;
	} cos_cfg_s;

	// default channel settings
	localparam cos_cfg_s COS_CH1_RST = '{pol: COS_POL_NO, src: COS_SRC_RUN};
	localparam cos_cfg_s COS_CH2_RST = '{pol: COS_POL_NO, src: COS_SRC_REMOTE};
	localparam cos_cfg_s COS_CH3_RST = '{pol: COS_POL_NC, src: COS_SRC_ALARM};

	// product conditions, from the controller (remote_in and inputs come from pins)
	typedef struct packed {
		logic operating;
		logic ready;
		logic alarm_stop;
		logic alarm_cont;
		logic alarm_sel;
		logic start_timer;
		logic stop_timer;
		logic pwr_recover;
		logic anti_freeze;
		logic warm_up;
	} cos_cond_s;

endpackage : cos_pkg

// [testbench/cos_customer.sv]
// Purpose: customer equipment model that holds the contact input pins
// Assumes: every input is alternate type, so levels are held between changes
// Notes:   momentary signalling is left out; pass-through is not faithful then
`timescale 1ns/1ps
module cos_customer (
	// clock
	input  wire logic       ref_clk,
	// pin levels the bench wants: {remote, input 2, input 1}
	input  wire logic [2:0] want,
	// customer pins
	output logic            contact_in1 = 1'b0,
	output logic            contact_in2 = 1'b0,
	output logic            remote_in   = 1'b0
);
	// change just after an edge, then hold as a level
	always @(posedge ref_clk) begin
		{remote_in, contact_in2, contact_in1} <= want;
	end
endmodule : cos_customer

// [testbench/tb.sv]
// Purpose: self-checking bench for the contact output selector
// Assumes: 125 MHz ref_clk, reset held six cycles, random seed 40
// Notes:   pin changes need about four edges, so checks wait six
`timescale 1ns/1ps
module tb;
	import cos_pkg::*;
	logic        ref_clk   = 1'b0;
	logic        rst       = 1'b1;
	logic [3:0]  reg_addr  = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr    = 1'b0;
	logic        reg_rd    = 1'b0;
	logic [31:0] reg_rdata;
	cos_cond_s   cond      = '0;
	logic [2:0]  pins      = 3'h0;
	logic        contact_in1;
	logic        contact_in2;
	logic        remote_in;
	logic [2:0]  contact_out;
	logic [4:0]  cfg [3];
	logic [31:0] rdv;
	int          miscompares = 0;
	int          comparisons = 0;
	int          seed        = 40;
	// 8 ns period
	always #4 ref_clk = ~ref_clk;
	cos_selector cos_selector_inst (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.cond(cond), .contact_in1(contact_in1), .contact_in2(contact_in2),
		.remote_in(remote_in), .contact_out(contact_out));
	cos_customer cos_customer_inst (.ref_clk(ref_clk), .want(pins), .contact_in1(contact_in1),
		.contact_in2(contact_in2), .remote_in(remote_in));
	// closed/open each channel should show, worked out from cfg
	function automatic logic [2:0] exp_out(input cos_cond_s k, input logic [2:0] p);
		logic [15:0] s;
		logic [2:0]  r;
		s = {1'b0, p[1], p[0], k.warm_up, k.anti_freeze, k.pwr_recover,
			k.stop_timer, k.start_timer, k.alarm_sel, k.alarm_stop | k.alarm_cont,
			k.alarm_cont, k.alarm_stop, k.ready, p[2], k.operating, 1'b0};
		for (int c = 0; c < 3; c++) begin
			r[c] = s[cfg[c][3:0]] ^ cfg[c][4];
		end
		return r;
	endfunction : exp_out
	task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
		comparisons++;
		if (g !== e) begin
			miscompares++;
			$display("wrong value %s expected %h seen %h", what, e, g);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr    <= 1'b0;
	endtask : wr
	// data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [3:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd   <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// let pins cross the synchroniser, then check contact_out and status word
	task automatic settle_check;
		repeat (6) @(posedge ref_clk);
		#1;
		chk("contact_out", {29'h0, exp_out(cond, pins)}, {29'h0, contact_out});
		rd(4'h3, rdv);
		chk("status", {29'h0, exp_out(cond, pins)}, rdv);
	endtask : settle_check
	task automatic end_sim;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : end_sim
	initial begin : main
		repeat (6) @(posedge ref_clk);
		rst <= 1'b0;
		cfg = '{5'h01, 5'h02, 5'h16};
		for (int c = 0; c < 3; c++) begin
			rd(4'(c), rdv);
			chk("cfg default", {27'h0, cfg[c]}, {27'h0, rdv[4:0]});
		end
		settle_check();
		$display("test defaults done");
		// walk every source code on every channel with random polarity and inputs
		for (int i = 0; i < 48; i++) begin
			for (int c = 0; c < 3; c++) begin
				cfg[c] = {1'($random(seed)), 4'((i + c) % 16)};
				wr(4'(c), {27'h0, cfg[c]});
			end
			cond <= 10'($random(seed));
			pins <= 3'($random(seed));
			settle_check();
			rd(4'(i % 3), rdv);
			chk("cfg readback", {27'h0, cfg[i % 3]}, {27'h0, rdv[4:0]});
		end
		$display("test sources done");
		// writes past the channels are ignored, unmapped reads give zero
		wr(4'h3, 32'h1F);
		wr(4'hF, 32'h1F);
		rd(4'h9, rdv);
		chk("unmapped read", 32'h0, rdv);
		settle_check();
		$display("test unmapped done");
		// second reset in mid-run brings the defaults back
		rst <= 1'b1;
		@(posedge ref_clk);
		#1 chk("out in reset", 32'h0, {29'h0, contact_out});
		rst <= 1'b0;
		cfg = '{5'h01, 5'h02, 5'h16};
		cond <= 10'($random(seed));
		settle_check();
		$display("test reset done");
		end_sim();
	end
	// watchdog, far beyond the roughly 800 cycles the tests take
	initial begin : watchdog
		#400000;
		miscompares++;
		end_sim();
	end
endmodule : tb
